// ### rmcc_pkg.sv
/*
 * Shared constants and carriers for the radio MAC channel configuration block.
 * Assumes a single 50 MHz core clock and an APB master with 32-bit data.
 */
package rmcc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int         ADDR_W      = 8;
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_APPLY   = 8'h04;
	localparam logic [7:0] OFF_NET     = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0C;
	localparam logic [7:0] OFF_ENMASK  = 8'h10;
	localparam logic [7:0] OFF_AVAIL   = 8'h20;
	localparam logic [7:0] OFF_TXBYTES = 8'h30;
	localparam logic [7:0] OFF_RSSI    = 8'h34;
	localparam logic [7:0] OFF_GOOD    = 8'h38;
	localparam logic [7:0] OFF_ACKTO   = 8'h3C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int RATE_LSB  = 0;
	localparam int PRE_LSB   = 4;
	localparam int RETRY_LSB = 8;
	localparam int EXTRA_LSB = 12;
	localparam int HOP_LSB   = 8;

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [1:0]  RST_RATE    = 2'h2;
	localparam logic [1:0]  RST_RATE_JP = 2'h1;
	localparam logic [15:0] RST_NET     = 16'h7FFF;
	localparam logic [15:0] NET_MAX     = 16'h7FFF;
	localparam logic [15:0] NET_FACTORY = 16'hFFFF;
	localparam logic [2:0]  RST_PRE     = 3'h0;
	localparam logic [3:0]  RST_RETRY   = 4'hA;
	localparam logic [2:0]  RST_EXTRA   = 3'h3;
	localparam logic [2:0]  EXTRA_MAX   = 3'h5;
	localparam logic [15:0] CNT16_MAX   = 16'hFFFF;
	localparam logic [1:0]  RATE_SLOW   = 2'h0;
	localparam logic [1:0]  RATE_FAST   = 2'h2;
	localparam logic [3:0]  HOP_LO      = 4'hA;
	localparam logic [3:0]  HOP_HI      = 4'h8;

	// ----------------------------------------
	// Channel set sizes (count of low ones; N_ALT_TOP is the top channel index of the alternating mask)
	// ----------------------------------------
	localparam int CHAN_MAX   = 128;
	localparam int N_US_LO    = 101;
	localparam int N_US_HI    = 50;
	localparam int N_AUS_LO   = 49;
	localparam int N_AUS_HI   = 24;
	localparam int N_NZ_LO    = 41;
	localparam int N_NZ_HI    = 11;
	localparam int N_JP_LO    = 38;
	localparam int N_DEF_ANZ  = 41;
	localparam int N_FIXED    = 50;
	localparam int N_ALT_TOP  = 98;

	typedef enum logic [1:0] {
		RG_US  = 2'b00,
		RG_AUS = 2'b01,
		RG_NZ  = 2'b11,
		RG_JP  = 2'b10
	} rmcc_region_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rmcc_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rmcc_apb_rsp_type;

	typedef struct packed {
		logic        valid;
		logic [2:0]  preamble;
		logic [15:0] netNum;
		logic        isAck;
		logic [7:0]  rssi;
	} rmcc_rx_type;

	typedef struct packed {
		logic [1:0] rate;
		logic       meshEnable;
		logic       syncSleepEnable;
		logic       spacingWide;
		logic [3:0] hopPatterns;
		logic       ackRequest;
		logic [3:0] retryLimit;
		logic [2:0] bcastSends;
		logic [2:0] preamble;
	} rmcc_cfg_type;

endpackage

// ### rmcc_top.sv
/*
 * Channel, rate, filter and diagnostic counter logic of a hopping radio MAC.
 * Assumes an APB master on core_clk and MAC datapath events on the same clock.
 */
// The implementer's own choices: the APB slave port and the placing of the registers.
// Notes on behaviour
// RL1: Mask bit zero is lowest frequency channel
// RL2: Spacing 250 kHz rates 0/1, 500 rate 2
// RL3: Rate 2 uses and reports fixed mask
// RL4: Active channel needs enable and available bit
// RL5: Software enables required count, same network-wide
// RL6: Australia/New Zealand enable mask is read-only
// RL7: Mask query returns mask in operation
// RL8: Rate codes 0,1,2; default 2 (the Japan build resets to rate 1)
// RL9: Rate 0 disables mesh and sync sleep
// RL10: Japan refuses rate 2
// RL11: Hop patterns 10 for rates 0/1, 8 otherwise
// RL12: Network up to 0x7FFF; 0xFFFF picks factory
// RL13: Preamble compared first, then network number
// RL14: Nonzero retry limit requests ack, retransmits
// RL15: Broadcasts sent extra count plus one
// RL16: Byte counter counts every sent byte, 32-bit
// RL17: Byte counter loadable with any value
// RL18: Last RSSI held, zero until packet
// RL19: Good frames exclude acks, saturate 0xFFFF
// RL20: Ack timeouts counted, saturate 0xFFFF
// RL21: Frame and timeout counters loadable
// RL22: Counters and RSSI clear at reset
// RL23: Parameter writes wait for apply
// RL24: Counter load beats same-cycle count
`timescale 1ns/1ps
module rmcc_top
	import rmcc_pkg::*;
#(
	parameter rmcc_region_type REGION      = RG_US,
	parameter int              CHAN_W      = 101,
	parameter logic [15:0]     FACTORY_NET = 16'h1234
)
(
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      clkEn,
	input  wire rmcc_pkg::rmcc_apb_req_type apbReq,
	output      rmcc_pkg::rmcc_apb_rsp_type apbRsp,
	input  wire logic                      txByteStrobe,
	input  wire logic                      ackTimeout,
	input  wire rmcc_pkg::rmcc_rx_type     rxIn,
	output      logic                      rxAccept,
	output      logic [CHAN_W-1:0]         activeChannels,
	output      rmcc_pkg::rmcc_cfg_type    cfgOut
);
	import rmcc_pkg::*;

	// ----------------------------------------
	// Mask helpers
	// ----------------------------------------
	function automatic logic [CHAN_MAX-1:0] onesMask(input int n);
		logic [CHAN_MAX-1:0] m;
		m = '0;
		for (int i = 0; i < CHAN_MAX; i++)
			m[i] = (i < n);
		return m;
	endfunction

	// Bit 0 is the lowest channel, upward from there
	function automatic logic [CHAN_MAX-1:0] availMask(input logic [1:0] r); // [RL1]
		logic hi;
		hi = (r == RATE_FAST);
		case (REGION)
			RG_AUS:  return onesMask(hi ? N_AUS_HI : N_AUS_LO);
			RG_NZ:   return onesMask(hi ? N_NZ_HI : N_NZ_LO);
			RG_JP:   return onesMask(N_JP_LO);
			default: return onesMask(hi ? N_US_HI : N_US_LO);
		endcase
	endfunction

	function automatic logic [CHAN_MAX-1:0] defaultMask();
		logic [CHAN_MAX-1:0] m;
		m = '0;
		for (int i = 0; i < CHAN_MAX; i++)
			m[i] = (i % 2 == 0) && (i <= N_ALT_TOP);
		case (REGION)
			RG_AUS, RG_NZ: return onesMask(N_DEF_ANZ);
			RG_JP:         return onesMask(N_JP_LO);
			default:       return m;
		endcase
	endfunction

	function automatic logic [15:0] sat16(input logic [15:0] v);
		return (v == CNT16_MAX) ? v : 16'(v + 16'h0001);
	endfunction

	localparam logic [CHAN_MAX-1:0] FIXED_MASK = onesMask(N_FIXED);
	localparam logic [1:0]          RATE_RST   = (REGION == RG_JP) ? RST_RATE_JP : RST_RATE;
	localparam logic                ROM_REGION = (REGION == RG_AUS) || (REGION == RG_NZ);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic                ready_q;
	wire logic           access   = apbReq.psel && apbReq.penable && clkEn;
	wire logic           wrDone   = access && ready_q && apbReq.pwrite;
	wire logic [7:0]     addr     = apbReq.paddr;
	wire logic [31:0]    wd       = apbReq.pwdata;
	wire logic           aligned  = (addr[1:0] == 2'b00);
	wire logic           hitCtrl  = (addr == OFF_CTRL);
	wire logic           hitApply = (addr == OFF_APPLY);
	wire logic           hitNet   = (addr == OFF_NET);
	wire logic           hitStat  = (addr == OFF_STATUS);
	wire logic           hitEn    = aligned && (addr[7:4] == OFF_ENMASK[7:4]);
	wire logic           hitAvail = aligned && (addr[7:4] == OFF_AVAIL[7:4]);
	wire logic           hitBytes = (addr == OFF_TXBYTES);
	wire logic           hitRssi  = (addr == OFF_RSSI);
	wire logic           hitGood  = (addr == OFF_GOOD);
	wire logic           hitAckTo = (addr == OFF_ACKTO);
	wire logic           mapped   = hitCtrl || hitApply || hitNet || hitStat || hitEn
		|| hitAvail || hitBytes || hitRssi || hitGood || hitAckTo;
	wire logic [6:0]     wordSel  = {addr[3:2], 5'b0_0000};

	// ----------------------------------------
	// Pending and applied parameters
	// ----------------------------------------
	logic [1:0]          ratePend_q,  rateAct_q;
	logic [2:0]          prePend_q,   preAct_q;
	logic [3:0]          retryPend_q, retryAct_q;
	logic [2:0]          extraPend_q, extraAct_q;
	logic [15:0]         netPend_q,   netAct_q;
	logic [CHAN_MAX-1:0] enPend_q,    enAct_q;
	logic [CHAN_MAX-1:0] enPend_d;

	wire logic [1:0]  wRate    = wd[RATE_LSB +: 2];
	wire logic [2:0]  wExtra   = wd[EXTRA_LSB +: 3];
	wire logic        rateOk   = (wRate <= RATE_FAST) // [RL8]
		&& !((REGION == RG_JP) && (wRate == RATE_FAST)); // [RL10]
	wire logic        extraOk  = (wExtra <= EXTRA_MAX);
	wire logic        netOk    = (wd[15:0] <= NET_MAX) || (wd[15:0] == NET_FACTORY); // [RL12]
	wire logic        doApply  = wrDone && hitApply;

	always_comb
	begin
		enPend_d = enPend_q;
		if (wrDone && hitEn && !ROM_REGION) // [RL6]
			enPend_d[wordSel +: 32] = wd;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ratePend_q  <= RATE_RST;
			prePend_q   <= RST_PRE;
			retryPend_q <= RST_RETRY;
			extraPend_q <= RST_EXTRA;
			netPend_q   <= RST_NET;
			enPend_q    <= defaultMask();
		end
		else if (clkEn)
		begin
			enPend_q <= enPend_d;
			if (wrDone && hitCtrl)
			begin
				if (rateOk)
					ratePend_q <= wRate;
				if (extraOk)
					extraPend_q <= wExtra;
				prePend_q   <= wd[PRE_LSB +: 3];
				retryPend_q <= wd[RETRY_LSB +: 4];
			end
			if (wrDone && hitNet && netOk)
				netPend_q <= wd[15:0];
		end
	end

	// Nothing reaches the radio until software applies it
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rateAct_q  <= RATE_RST;
			preAct_q   <= RST_PRE;
			retryAct_q <= RST_RETRY;
			extraAct_q <= RST_EXTRA;
			netAct_q   <= RST_NET;
			enAct_q    <= defaultMask();
		end
		else if (clkEn && doApply) // [RL23]
		begin
			rateAct_q  <= ratePend_q;
			preAct_q   <= prePend_q;
			retryAct_q <= retryPend_q;
			extraAct_q <= extraPend_q;
			netAct_q   <= netPend_q;
			enAct_q    <= enPend_q;
		end
	end

	// ----------------------------------------
	// Operating channel set
	// ----------------------------------------
	wire logic [CHAN_MAX-1:0] availNow = availMask(rateAct_q);
	wire logic [CHAN_MAX-1:0] userMask = ROM_REGION ? defaultMask() : enAct_q; // [RL6]
	wire logic [CHAN_MAX-1:0] opMask   =
		(rateAct_q == RATE_FAST) ? FIXED_MASK : userMask; // [RL3] [RL7]
	wire logic [CHAN_MAX-1:0] activeD  = opMask & availNow; // [RL4]
	wire logic                rateSlow = (rateAct_q == RATE_SLOW);

	rmcc_cfg_type cfgD;
	always_comb
	begin
		cfgD                 = '0;
		cfgD.rate            = rateAct_q;
		cfgD.meshEnable      = !rateSlow; // [RL9]
		cfgD.syncSleepEnable = !rateSlow; // [RL9]
		cfgD.spacingWide     = (rateAct_q == RATE_FAST); // [RL2]
		cfgD.hopPatterns     = (rateAct_q == RATE_FAST) ? HOP_HI : HOP_LO; // [RL11]
		cfgD.ackRequest      = (retryAct_q != 4'h0); // [RL14]
		cfgD.retryLimit      = retryAct_q; // [RL14]
		cfgD.bcastSends      = 3'(extraAct_q + 3'h1); // [RL15]
		cfgD.preamble        = preAct_q;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cfgOut         <= '0;
			activeChannels <= '0;
		end
		else if (clkEn)
		begin
			cfgOut         <= cfgD;
			activeChannels <= activeD[CHAN_W-1:0];
		end
	end

	// ----------------------------------------
	// Receive filter, preamble before network
	// ----------------------------------------
	logic        stgValid_q;
	logic        stgPreOk_q;
	logic [15:0] stgNet_q;
	logic        stgAck_q;
	logic [7:0]  stgRssi_q;
	wire logic [15:0] netEff = (netAct_q == NET_FACTORY) ? FACTORY_NET : netAct_q; // [RL12]
	wire logic        accD   = stgValid_q && stgPreOk_q && (stgNet_q == netEff); // [RL13]
	wire logic        goodEv = accD && !stgAck_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			stgValid_q <= 1'b0;
			stgPreOk_q <= 1'b0;
			stgNet_q   <= 16'h0000;
			stgAck_q   <= 1'b0;
			stgRssi_q  <= 8'h00;
			rxAccept   <= 1'b0;
		end
		else if (clkEn)
		begin
			stgValid_q <= rxIn.valid;
			stgPreOk_q <= (rxIn.preamble == preAct_q); // [RL13]
			stgNet_q   <= rxIn.netNum;
			stgAck_q   <= rxIn.isAck;
			stgRssi_q  <= rxIn.rssi;
			rxAccept   <= accD;
		end
	end

	// ----------------------------------------
	// Diagnostic counters
	// ----------------------------------------
	logic [31:0] txBytes_q;
	logic [7:0]  rssi_q;
	logic [15:0] good_q;
	logic [15:0] ackTo_q;

	// Load first, so a count in the same cycle is dropped
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			txBytes_q <= 32'h0000_0000; // [RL22]
			rssi_q    <= 8'h00; // [RL18]
			good_q    <= 16'h0000;
			ackTo_q   <= 16'h0000;
		end
		else if (clkEn)
		begin
			if (wrDone && hitBytes)
				txBytes_q <= wd; // [RL17] [RL24]
			else if (txByteStrobe)
				txBytes_q <= 32'(txBytes_q + 32'h0000_0001); // [RL16]
			if (goodEv)
				rssi_q <= stgRssi_q; // [RL18]
			if (wrDone && hitGood)
				good_q <= wd[15:0]; // [RL21] [RL24]
			else if (goodEv)
				good_q <= sat16(good_q); // [RL19]
			if (wrDone && hitAckTo)
				ackTo_q <= wd[15:0]; // [RL21] [RL24]
			else if (ackTimeout)
				ackTo_q <= sat16(ackTo_q); // [RL20]
		end
	end

	// ----------------------------------------
	// Read mux and bus answer
	// ----------------------------------------
	// One wait state: data is registered in the first access cycle
	wire logic [31:0] rdCtrl = {17'h0_0000, extraPend_q, retryPend_q, 1'b0,
		prePend_q, 2'b00, ratePend_q};
	wire logic [31:0] rdStat = {20'h0_0000, cfgD.hopPatterns, 1'b0, cfgD.spacingWide,
		cfgD.syncSleepEnable, cfgD.meshEnable, 2'b00, rateAct_q};
	wire logic [31:0] rdData =
		hitCtrl  ? rdCtrl :
		hitNet   ? {16'h0000, netPend_q} :
		hitStat  ? rdStat :
		hitEn    ? opMask[wordSel +: 32] :
		hitAvail ? availNow[wordSel +: 32] :
		hitBytes ? txBytes_q :
		hitRssi  ? {24'h00_0000, rssi_q} :
		hitGood  ? {16'h0000, good_q} :
		hitAckTo ? {16'h0000, ackTo_q} : 32'h0000_0000;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ready_q <= 1'b0;
			apbRsp  <= '0;
		end
		else if (clkEn)
		begin
			ready_q        <= access && !ready_q;
			apbRsp.pready  <= access && !ready_q;
			apbRsp.prdata  <= (access && !ready_q) ? rdData : 32'h0000_0000;
			apbRsp.pslverr <= access && !ready_q && !mapped;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence applyStep;
		clkEn && doApply;
	endsequence

	sequence fastActive;
		clkEn && (rateAct_q == RATE_FAST);
	endsequence

	chk_rate_hold_apply: assert property ( // [RL23]
		clkEn && !doApply |=> $stable(rateAct_q) && $stable(enAct_q))
		else $error("applied parameters moved without apply");
	chk_apply_copies: assert property ( // [RL23]
		applyStep |=> rateAct_q == $past(ratePend_q) && netAct_q == $past(netPend_q))
		else $error("apply did not copy pending values");
	chk_fixed_mask: assert property ( // [RL3]
		fastActive |=> activeChannels == (FIXED_MASK[CHAN_W-1:0] & $past(availNow[CHAN_W-1:0])))
		else $error("rate 2 not using fixed mask");
	chk_active_subset: assert property ( // [RL4]
		clkEn |=> (activeChannels & ~$past(availNow[CHAN_W-1:0])) == '0)
		else $error("active channel outside available set");
	chk_slow_no_mesh: assert property ( // [RL9]
		clkEn && rateSlow |=> !cfgOut.meshEnable && !cfgOut.syncSleepEnable)
		else $error("rate 0 left mesh or sleep on");
	chk_fast_spacing: assert property ( // [RL2] [RL11]
		fastActive |=> cfgOut.spacingWide && cfgOut.hopPatterns == HOP_HI)
		else $error("rate 2 spacing or hop count wrong");
	chk_jp_no_fast: assert property ( // [RL10]
		(REGION == RG_JP) |-> ratePend_q != RATE_FAST)
		else $error("rate 2 accepted in Japan");
	chk_filter_order: assert property ( // [RL13]
		rxAccept |-> $past(stgPreOk_q) && $past(stgNet_q) == $past(netEff))
		else $error("frame accepted without preamble and network match");
	chk_good_sat: assert property ( // [RL19]
		clkEn && good_q == CNT16_MAX && !(wrDone && hitGood) |=> good_q == CNT16_MAX)
		else $error("good frame counter wrapped");
	chk_ackto_count: assert property ( // [RL20]
		clkEn && ackTimeout && !(wrDone && hitAckTo) && ackTo_q != CNT16_MAX
		|=> ackTo_q == 16'($past(ackTo_q) + 16'h0001))
		else $error("ack timeout not counted");
	chk_load_wins: assert property ( // [RL24]
		wrDone && hitBytes |=> txBytes_q == $past(wd))
		else $error("byte counter load lost to count");
	chk_bcast_sends: assert property ( // [RL15]
		clkEn ##1 clkEn |-> cfgOut.bcastSends == 3'($past(extraAct_q) + 3'h1))
		else $error("broadcast send count wrong");
	chk_reset_clear: assert property (disable iff (1'b0) rst && clkEn // [RL22]
		|=> txBytes_q == '0 && rssi_q == '0 && good_q == '0 && ackTo_q == '0)
		else $error("counters not cleared by reset");
	chk_apb_wait: assert property (
		access && !ready_q |=> apbRsp.pready ##1 !apbRsp.pready)
		else $error("bus answer not one cycle");

endmodule

// ### rmcc_remote_node.sv
/*
 * Remote radio node model: drives received frame headers into the block.
 * Assumes core_clk and a one-cycle send request from the bench.
 */
`timescale 1ns/1ps
module rmcc_remote_node
	import rmcc_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  send,
	input  wire logic [2:0]            pre,
	input  wire logic [15:0]           net,
	input  wire logic                  ack,
	input  wire logic [7:0]            rssi,
	output      rmcc_pkg::rmcc_rx_type rxOut
);
	logic [27:0] junk_q;
	// ----------------------------------------
	// Frame drive
	// ----------------------------------------
	// Idle fields churn so a stale header never looks held
	always_ff @(posedge core_clk)
	begin
		junk_q <= rst ? 28'h0 : junk_q + 28'h123_4567;
		if (send)
			rxOut <= {1'b1, pre, net, ack, rssi}; // Preamble then network
		else
			rxOut <= {1'b0, junk_q};
	end
endmodule

// ### tb_radio_mac_channel_config.sv
/*
 * Self-checking bench for the radio MAC channel configuration block.
 * Assumes the US region build and an APB master on core_clk.
 */
`timescale 1ns/1ps
module tb_radio_mac_channel_config;
	import rmcc_pkg::*;
	localparam int          CW   = 101;
	localparam logic [15:0] FNET = 16'h0BAD; // Arbitrary value
	logic             core_clk = 1'b0;
	logic             rst = 1'b1;
	logic             clkEn = 1'b1;
	rmcc_apb_req_type apbReq = '0;
	rmcc_apb_rsp_type apbRsp;
	logic             txByteStrobe = 1'b0;
	logic             ackTimeout = 1'b0;
	rmcc_rx_type      rxIn;
	logic             rxAccept;
	logic [CW-1:0]    activeChannels;
	rmcc_cfg_type     cfgOut;
	logic             send = 1'b0;
	logic [2:0]       fPre = '0;
	logic [15:0]      fNet = '0;
	logic             fAck = 1'b0;
	logic [7:0]       fRssi = '0;
	int               err_count = 0;
	int               samples_checked = 0;
	int               cyc = 0;
	logic [31:0]      rdat;
	logic             rerr;
	logic [2:0]       myPre;
	logic [15:0]      myNet;
	int               good = 0;
	logic [7:0]       lastRssi = '0;
	logic [CW-1:0]    actExp;
	logic [1:0]       cur;
	logic [2:0]       curE;
	logic [3:0]       rt;
	logic [2:0]       ex;
	logic [31:0]      val;
	int               k;
	int               n;

	always #10 core_clk = ~core_clk;

	rmcc_top #(.REGION(RG_US), .CHAN_W(CW), .FACTORY_NET(FNET)) rmcc_top_i (
		.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp),
		.txByteStrobe(txByteStrobe), .ackTimeout(ackTimeout), .rxIn(rxIn),
		.rxAccept(rxAccept), .activeChannels(activeChannels), .cfgOut(cfgOut));

	rmcc_remote_node rmcc_remote_node_i (.core_clk(core_clk), .rst(rst), .send(send),
		.pre(fPre), .net(fNet), .ack(fAck), .rssi(fRssi), .rxOut(rxIn));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 30000)
		begin
			err_count++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Holds the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge core_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			t++;
		end
		while (apbRsp.pready !== 1'b1 && t < 40);
		if (t >= 40)
			chk("pready", {31'h0, apbRsp.pready}, 32'h1);
		rdat = apbRsp.prdata;
		rerr = apbRsp.pslverr;
		apbReq <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rdat, e);
	endtask

	task automatic apply();
		apb(1'b1, OFF_APPLY, 32'h0);
		repeat (2) @(negedge core_clk);
	endtask

	function automatic logic [31:0] stExp(input logic [1:0] r);
		logic [31:0] s;
		s = 32'h0;
		s[1:0] = r;
		s[4] = (r != 2'h0);
		s[5] = (r != 2'h0);
		s[6] = (r == 2'h2);
		s[11:8] = (r == 2'h2) ? 4'h8 : 4'hA;
		return s;
	endfunction

	task automatic frame(input logic [2:0] p, input logic [15:0] nt, input logic a,
		input logic [7:0] rs);
		logic acc;
		acc = (p == myPre) && (nt == myNet);
		@(posedge core_clk);
		send <= 1'b1;
		fPre <= p;
		fNet <= nt;
		fAck <= a;
		fRssi <= rs;
		@(posedge core_clk);
		send <= 1'b0;
		repeat (3) @(negedge core_clk);
		chk("rxAccept", {31'h0, rxAccept}, {31'h0, acc}); // Filter
		if (acc && !a)
		begin
			if (good < 65535)
				good++;
			lastRssi = rs;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(52240));
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		rd(OFF_CTRL, 32'h0000_3A02, "ctrl"); // Defaults
		rd(OFF_NET, 32'h0000_7FFF, "net"); // Default
		rd(OFF_STATUS, stExp(2'h2), "status"); // Wide spacing
		for (k = 0; k < 4; k++)
			rd(OFF_TXBYTES + 8'(4 * k), 32'h0, "counter"); // Cleared
		rd(OFF_ENMASK, 32'hFFFF_FFFF, "mask0"); // Fixed
		rd(OFF_ENMASK + 8'h04, 32'h0003_FFFF, "mask1"); // Fixed
		actExp = '0;
		actExp[49:0] = '1;
		chk("active", {31'h0, activeChannels === actExp}, 32'h1); // Both bits
		chk("cfg", {cfgOut.bcastSends, cfgOut.retryLimit, cfgOut.ackRequest}, 32'h0000_0095);
		$display("test reset done");

		apb(1'b1, OFF_ENMASK, 32'h0);
		apb(1'b1, OFF_ENMASK + 8'h04, 32'hFFFC_0000); // Fifty channels
		apb(1'b1, OFF_ENMASK + 8'h08, 32'hFFFF_FFFF); // Fifty channels
		apb(1'b1, OFF_ENMASK + 8'h0C, 32'h0000_000F); // Fifty channels
		cur = 2'h2;
		for (k = 0; k < 4; k++)
		begin
			apb(1'b1, OFF_CTRL, 32'h0000_3A00 | 32'(k ^ 1));
			rd(OFF_STATUS, stExp(cur), "pending"); // Held until apply
			if ((k ^ 1) < 3)
				cur = 2'(k ^ 1);
			apply();
			rd(OFF_STATUS, stExp(cur), "status"); // Codes
			val = stExp(cur);
			chk("cfgRate", {cfgOut.rate, cfgOut.meshEnable, cfgOut.syncSleepEnable,
				cfgOut.spacingWide, cfgOut.hopPatterns}, {val[1:0], val[4], val[5], val[6],
				val[11:8]}); // Mesh off at slow rate
			if (cur == 2'h1)
			begin
				rd(OFF_ENMASK + 8'h04, 32'hFFFC_0000, "userMask"); // Operating
				actExp = '0;
				actExp[99:50] = '1;
				chk("active", {31'h0, activeChannels === actExp}, 32'h1); // Both bits
			end
		end
		rd(OFF_ENMASK, 32'hFFFF_FFFF, "mask0"); // Fixed again
		$display("test rates done");

		curE = 3'h3;
		for (k = 0; k < 4; k++)
		begin
			rt = (k == 0) ? 4'h0 : 4'($urandom);
			ex = (k == 0) ? 3'h5 : 3'($urandom);
			apb(1'b1, OFF_CTRL, {17'h0, ex, rt, 8'h02});
			if (ex <= 3'h5)
				curE = ex;
			apply();
			chk("retry", {cfgOut.ackRequest, cfgOut.retryLimit}, {rt != 4'h0, rt});
			chk("bcast", {29'h0, cfgOut.bcastSends}, {29'h0, curE + 3'h1});
		end
		$display("test sends done");

		myPre = 3'($urandom);
		myNet = 16'($urandom_range(0, 32767));
		apb(1'b1, OFF_CTRL, {17'h0, 3'h3, 4'hA, 1'b0, myPre, 4'h2});
		apb(1'b1, OFF_NET, {16'h0, myNet});
		apply();
		chk("pre", {29'h0, cfgOut.preamble}, {29'h0, myPre}); // Own preamble
		apb(1'b1, OFF_NET, 32'h0000_8000);
		rd(OFF_NET, {16'h0, myNet}, "netRange"); // Above limit kept out
		for (k = 0; k < 16; k++)
		begin
			n = $urandom_range(0, 3);
			frame((n == 1) ? myPre ^ 3'h1 : myPre, (n == 2) ? myNet ^ 16'h0100 : myNet,
				n == 3, 8'($urandom));
		end
		rd(OFF_GOOD, 32'(good), "good"); // Non-ack only
		rd(OFF_RSSI, {24'h0, lastRssi}, "rssi"); // Last accepted non-ack frame
		apb(1'b1, OFF_NET, 32'h0000_FFFF);
		apply();
		myNet = FNET;
		frame(myPre, FNET, 1'b0, 8'h60); // Factory number
		apb(1'b1, OFF_GOOD, 32'h0000_FFFE);
		good = 65534;
		frame(myPre, FNET, 1'b0, 8'h61);
		frame(myPre, FNET, 1'b0, 8'h62);
		rd(OFF_GOOD, 32'h0000_FFFF, "goodSat"); // Load, saturate
		$display("test rx done");

		for (k = 0; k < 2; k++)
		begin
			val = (k == 0) ? 32'hFFFF_FFFE : $urandom;
			n = $urandom_range(1, 20);
			apb(1'b1, OFF_TXBYTES, val);
			@(posedge core_clk);
			txByteStrobe <= 1'b1;
			repeat (n) @(posedge core_clk);
			txByteStrobe <= 1'b0;
			rd(OFF_TXBYTES, val + 32'(n), "txBytes"); // Load, count, wrap
		end
		apb(1'b1, OFF_ACKTO, 32'h0000_FFF0);
		@(posedge core_clk);
		ackTimeout <= 1'b1;
		repeat (20) @(posedge core_clk);
		ackTimeout <= 1'b0;
		rd(OFF_ACKTO, 32'h0000_FFFF, "ackTo"); // Saturates
		@(posedge core_clk);
		txByteStrobe <= 1'b1;
		apb(1'b1, OFF_TXBYTES, 32'h1234_5678);
		txByteStrobe <= 1'b0;
		rd(OFF_TXBYTES, 32'h1234_5678, "loadWins"); // Write beats count
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", {31'h0, rerr}, 32'h1);
		apb(1'b1, OFF_AVAIL, 32'h0);
		rd(OFF_AVAIL, 32'hFFFF_FFFF, "avail"); // Low channels first
		$display("test counters done");

		@(posedge core_clk);
		clkEn <= 1'b0;
		txByteStrobe <= 1'b1;
		repeat (5) @(posedge core_clk);
		clkEn <= 1'b1;
		txByteStrobe <= 1'b0;
		rd(OFF_TXBYTES, 32'h1234_5678, "frozen"); // Enable low holds count
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(OFF_GOOD, 32'h0, "goodRst"); // Volatile
		rd(OFF_RSSI, 32'h0, "rssiRst"); // Zero until packet
		rd(OFF_TXBYTES, 32'h0, "bytesRst"); // Volatile
		rd(OFF_CTRL, 32'h0000_3A02, "ctrlRst"); // Defaults again
		$display("test second reset done");
		results();
	end
endmodule
